/* File: rtl/flash_cmd_pkg.sv */
/*
  Constants and carrier types for the serial flash instruction decoder.
  Assumes a host that frames instructions with an active-low select.
*/
package flash_cmd_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_VWREN    = 8'h50;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_RDSR1    = 8'h05;
  localparam logic [7:0] OP_RDSR2    = 8'h35;
  localparam logic [7:0] OP_RDSR3    = 8'h15;
  localparam logic [7:0] OP_WRSR1    = 8'h01;
  localparam logic [7:0] OP_WRSR2    = 8'h31;
  localparam logic [7:0] OP_WRSR3    = 8'h11;
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FREAD    = 8'h0B;
  localparam logic [7:0] OP_DOREAD   = 8'h3B;
  localparam logic [7:0] OP_DIOREAD  = 8'hBB;
  localparam logic [7:0] OP_QOREAD   = 8'h6B;
  localparam logic [7:0] OP_QIOREAD  = 8'hEB;
  localparam logic [7:0] OP_QWREAD   = 8'hE7;
  localparam logic [7:0] OP_PP       = 8'h02;
  localparam logic [7:0] OP_QPP      = 8'h32;
  localparam logic [7:0] OP_SE       = 8'h20;
  localparam logic [7:0] OP_BE32     = 8'h52;
  localparam logic [7:0] OP_BE64     = 8'hD8;
  localparam logic [7:0] OP_CE1      = 8'hC7;
  localparam logic [7:0] OP_CE2      = 8'h60;
  localparam logic [7:0] OP_SCER     = 8'h44;
  localparam logic [7:0] OP_SCPR     = 8'h42;
  localparam logic [7:0] OP_SCRD     = 8'h48;
  localparam logic [7:0] OP_SUSP     = 8'h75;
  localparam logic [7:0] OP_RESM     = 8'h7A;
  localparam logic [7:0] OP_RSTEN    = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;
  localparam logic [7:0] OP_WRAP     = 8'h77;
  localparam logic [7:0] OP_MFID     = 8'h90;
  localparam logic [7:0] OP_PARTID   = 8'h9F;

  // ==========================================================================
  // field layout
  localparam int        OPCODE_BITS   = 8;
  localparam int        PAGE_BYTES    = 256;
  localparam int        SEC_REG_BYTE  = 8;
  localparam logic [7:0] SEC_HI_BYTE  = 8'h00;
  localparam logic [7:0] SEC_REG1     = 8'h40;
  localparam logic [7:0] SEC_REG2     = 8'h80;
  localparam logic [7:0] SEC_REG3     = 8'hC0;
  localparam int        WRAP_CLK_IDX  = 6;
  localparam int        WRAP_DUMMIES  = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] STATUS_RST   = 8'h00;

  // ==========================================================================
  // carriers
  typedef enum logic [1:0] {
    LANE_X1 = 2'b00,
    LANE_X2 = 2'b01,
    LANE_X4 = 2'b10
  } lane_width_t;

  typedef enum logic [2:0] {
    CL_NONE  = 3'b000,
    CL_READ  = 3'b001,
    CL_WRITE = 3'b010,
    CL_MODE  = 3'b011,
    CL_SUSP  = 3'b100
  } op_class_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data0;
    logic [7:0]  data1;
    logic [8:0]  count;
  } cmd_t;

endpackage : flash_cmd_pkg

/* File: rtl/flash_cmd_decoder.sv */
/*
  Instruction front end of a serial flash: shifts in opcode, address,
  mode and data on 1/2/4 lines in the link clock domain, then hands a
  finished instruction to the core domain through a toggle handshake.
  Assumes the array core reports busy and protection, and that the link
  clock only runs while select is low.
*/
`timescale 1ns/10ps

module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter int WSR_CYCLES = 16
) (
  // core clock and control
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // link pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output logic [3:0]       io_out,
  output logic [3:0]       io_oe_n,
  // array core side
  input  wire logic        array_busy,
  input  wire logic        region_protected,
  input  wire logic [7:0]  read_byte,
  output logic [7:0]       status1,
  output logic [7:0]       status2,
  output logic [7:0]       status3,
  output logic             cmd_valid,
  output logic [7:0]       cmd_opcode,
  output logic [23:0]      cmd_addr,
  output logic [7:0]       cmd_data,
  output logic [8:0]       cmd_count,
  output logic [2:0]       wrap_setting,
  output logic             write_enable_latch,
  output logic             busy
);

  initial begin
    if (WSR_CYCLES < 1) $error("WSR_CYCLES must be positive");
  end

  // ==========================================================================
  // reset release
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ==========================================================================
  // link domain: shifting (select high holds it in reset)
  function automatic lane_width_t in_lanes(input logic [7:0] op);
    case (op)
      OP_DIOREAD:             in_lanes = LANE_X2;
      OP_QIOREAD, OP_QWREAD:  in_lanes = LANE_X4;
      default:                in_lanes = LANE_X1;
    endcase
  endfunction : in_lanes

  function automatic lane_width_t data_lanes(input logic [7:0] op);
    case (op)
      OP_DOREAD, OP_DIOREAD:            data_lanes = LANE_X2;
      OP_QOREAD, OP_QIOREAD, OP_QWREAD,
      OP_QPP:                           data_lanes = LANE_X4;
      default:                          data_lanes = LANE_X1;
    endcase
  endfunction : data_lanes

  logic [7:0]  op_q;
  logic [3:0]  bitcnt_q;
  logic [5:0]  bytecnt_q;
  logic [7:0]  sh_q;
  logic [23:0] addr_q;
  logic [7:0]  d0_q, d1_q;
  logic [8:0]  cnt_q;
  logic [2:0]  wrap_q;
  logic        done_tg_q;
  logic        in_op_w;
  lane_width_t lw_w;
  logic [3:0]  step_w;
  logic [7:0]  byte_w;
  logic        byte_end_w;

  assign in_op_w = (bytecnt_q == 6'd0);
  // opcode always single line; later fields by lane count
  assign lw_w    = in_op_w ? LANE_X1
                 : (bytecnt_q >= 6'd4 && !(op_q == OP_DIOREAD
                    || op_q == OP_QIOREAD || op_q == OP_QWREAD))
                   ? data_lanes(op_q) : in_lanes(op_q);
  assign step_w  = (lw_w == LANE_X4) ? 4'd4 :
                   (lw_w == LANE_X2) ? 4'd2 : 4'd1;
  // msb first; dual odd bits on line one, quad nibble msb on line three
  assign byte_w  = (lw_w == LANE_X4) ? {sh_q[3:0], io_in} :
                   (lw_w == LANE_X2) ? {sh_q[5:0], io_in[1:0]} :
                                       {sh_q[6:0], io_in[0]};
  assign byte_end_w = (bitcnt_q + step_w) == 4'd8;

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bitcnt_q  <= 4'd0;
      bytecnt_q <= 6'd0;
      sh_q      <= 8'h00;
    end else begin
      sh_q      <= byte_w;
      bitcnt_q  <= byte_end_w ? 4'd0 : bitcnt_q + step_w;
      if (byte_end_w && bytecnt_q != 6'h3F)
        bytecnt_q <= bytecnt_q + 6'd1;
    end
  end

  logic [5:0] dstart_w;
  // status writes carry data straight after the opcode
  assign dstart_w = (op_q == OP_WRSR1 || op_q == OP_WRSR2
                     || op_q == OP_WRSR3) ? 6'd1 : 6'd4;

  // captured fields survive select rise for the core to read
  always_ff @(posedge sclk) begin
    if (byte_end_w) begin
      if (in_op_w) begin
        op_q  <= byte_w;
        cnt_q <= 9'd0;
      end else if (bytecnt_q < dstart_w) begin
        addr_q <= {addr_q[15:0], byte_w};
      end else begin
        if (bytecnt_q == dstart_w)
          d0_q <= byte_w;
        if (bytecnt_q == dstart_w + 6'd1)
          d1_q <= byte_w;
        if (cnt_q != 9'(PAGE_BYTES))
          cnt_q <= cnt_q + 9'd1;
      end
    end
    if (op_q == OP_WRAP && bytecnt_q == 6'(WRAP_DUMMIES + 1)
        && bitcnt_q == 4'(WRAP_CLK_IDX))
      wrap_q <= io_in[2:0];
  end

  // select rise: hand the instruction over with its byte alignment
  logic aligned_q;
  always_ff @(posedge cs_n or negedge rst_n_q) begin
    if (!rst_n_q) begin
      done_tg_q <= 1'b0;
      aligned_q <= 1'b0;
    end else begin
      done_tg_q <= ~done_tg_q;
      aligned_q <= (bitcnt_q == 4'd0) && (bytecnt_q != 6'd0);
    end
  end

  // ==========================================================================
  // link domain: response drive on falling edge
  logic [7:0] resp_w;
  logic [7:0] out_sh_q;
  logic       drive_q;
  logic       rd_phase_w;
  logic [5:0] rd_start_w;

  // io reads answer only after the mode byte
  assign rd_start_w = (op_q == OP_DIOREAD || op_q == OP_QIOREAD
                       || op_q == OP_QWREAD) ? 6'd5 : 6'd4;
  assign resp_w = (op_q == OP_RDSR1) ? status1 :
                  (op_q == OP_RDSR2) ? status2 :
                  (op_q == OP_RDSR3) ? status3 : read_byte;
  // reads need no aligned end, a cut anywhere is harmless
  assign rd_phase_w = !in_op_w && (op_q == OP_RDSR1 || op_q == OP_RDSR2
                      || op_q == OP_RDSR3 || (!busy && bytecnt_q >= rd_start_w
                      && (op_q == OP_READ || op_q == OP_FREAD
                      || op_q == OP_DOREAD || op_q == OP_QOREAD
                      || op_q == OP_DIOREAD || op_q == OP_QIOREAD
                      || op_q == OP_MFID || op_q == OP_PARTID)));

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_sh_q <= 8'h00;
      drive_q  <= 1'b0;
    end else begin
      drive_q  <= rd_phase_w;
      // status byte reloaded each byte, so it repeats
      out_sh_q <= (bitcnt_q == 4'd0) ? resp_w : out_sh_q << step_w;
    end
  end

  always_comb begin
    io_out  = 4'h0;
    io_oe_n = 4'hF;
    if (drive_q) begin
      case (lw_w)
        LANE_X4: begin
          io_out  = out_sh_q[7:4];
          io_oe_n = 4'h0;
        end
        LANE_X2: begin
          io_out  = {2'b00, out_sh_q[7:6]};
          io_oe_n = 4'hC;
        end
        default: begin
          io_out  = {2'b00, out_sh_q[7], 1'b0};
          io_oe_n = 4'hD;
        end
      endcase
    end
  end

  // ==========================================================================
  // core domain: toggle crossing and execution
  logic tg_s1_q, tg_s2_q, tg_s3_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end else if (clk_en) begin
      tg_s1_q <= done_tg_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end

  logic       done_w;
  op_class_t  cls_w;
  logic       sec_ok_w;
  logic       accept_w;
  assign done_w = clk_en && (tg_s2_q != tg_s3_q);

  // security register decode
  assign sec_ok_w = addr_q[23:16] == SEC_HI_BYTE
                 && (addr_q[15:8] == SEC_REG1 || addr_q[15:8] == SEC_REG2
                 ||  addr_q[15:8] == SEC_REG3);

  assign cls_w = (op_q == OP_PP || op_q == OP_QPP || op_q == OP_SE
               || op_q == OP_BE32 || op_q == OP_BE64 || op_q == OP_CE1
               || op_q == OP_CE2 || op_q == OP_SCER || op_q == OP_SCPR
               || op_q == OP_WRSR1 || op_q == OP_WRSR2
               || op_q == OP_WRSR3) ? CL_WRITE :
               (op_q == OP_WREN || op_q == OP_WRDI || op_q == OP_VWREN
               || op_q == OP_RSTEN || op_q == OP_RST
               || op_q == OP_WRAP) ? CL_MODE :
               (op_q == OP_SUSP || op_q == OP_RESM) ? CL_SUSP : CL_NONE;

  logic [7:0] s1_q, s2_q, s3_q, nv1_q, nv2_q, nv3_q;
  logic       wel_q, vol_q, rsten_q;
  logic [$clog2(WSR_CYCLES+1)-1:0] wsr_q;
  logic       wsr_busy_w;
  assign wsr_busy_w = (wsr_q != '0);
  assign busy       = array_busy | wsr_busy_w;

  assign accept_w = done_w && !busy
                 && aligned_q
                 && (cls_w != CL_WRITE || wel_q
                     || (vol_q && (op_q == OP_WRSR1
                     || op_q == OP_WRSR2 || op_q == OP_WRSR3)))
                 && !(cls_w == CL_WRITE && region_protected)
                 && ((op_q != OP_SCER && op_q != OP_SCPR) || sec_ok_w)
                 && ((op_q != OP_PP && op_q != OP_QPP && op_q != OP_SCPR)
                     || cnt_q != 9'd0);

  logic [7:0] wr_op_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q <= STATUS_RST;  s2_q <= STATUS_RST;  s3_q <= STATUS_RST;
      nv1_q <= STATUS_RST; nv2_q <= STATUS_RST; nv3_q <= STATUS_RST;
      wel_q <= 1'b0;  vol_q <= 1'b0;  rsten_q <= 1'b0;
      wsr_q <= '0;
      cmd_valid <= 1'b0;
      wr_op_q   <= 8'h00;
    end else if (clk_en) begin
      cmd_valid <= 1'b0;
      if (wsr_busy_w) begin
        wsr_q <= wsr_q - 1'b1;
        if (wsr_q == 1) wel_q <= 1'b0;
      end
      // suspend and resume pass to the core even while busy
      if (done_w && aligned_q && cls_w == CL_SUSP) begin
        cmd_valid <= 1'b1;
        wr_op_q   <= op_q;
      end
      if (accept_w) begin
        rsten_q <= (op_q == OP_RSTEN);
        case (op_q)
          OP_WREN:  wel_q <= 1'b1;
          OP_WRDI:  wel_q <= 1'b0;
          OP_VWREN: vol_q <= 1'b1;
          OP_RST: begin
            if (rsten_q) begin
              s1_q <= nv1_q; s2_q <= nv2_q; s3_q <= nv3_q;
              wel_q <= 1'b0; vol_q <= 1'b0;
            end
          end
          OP_WRSR1, OP_WRSR2, OP_WRSR3: begin
            vol_q <= 1'b0;
            if (op_q == OP_WRSR1) s1_q <= d0_q;
            if (op_q == OP_WRSR1 && cnt_q >= 9'd2) s2_q <= d1_q;
            if (op_q == OP_WRSR2) s2_q <= d0_q;
            if (op_q == OP_WRSR3) s3_q <= d0_q;
            if (!vol_q) begin
              if (op_q == OP_WRSR1) nv1_q <= d0_q;
              if (op_q == OP_WRSR1 && cnt_q >= 9'd2) nv2_q <= d1_q;
              if (op_q == OP_WRSR2) nv2_q <= d0_q;
              if (op_q == OP_WRSR3) nv3_q <= d0_q;
              wsr_q <= ($bits(wsr_q))'(WSR_CYCLES);
            end
          end
          default: begin
            if (cls_w == CL_WRITE) begin
              cmd_valid <= 1'b1;
              wr_op_q   <= op_q;
              wel_q     <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // unknown opcodes raise no command; they still clear rsten_q and refresh cmd_addr, cmd_data and cmd_count
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_opcode <= 8'h00; cmd_addr <= 24'h0; cmd_data <= 8'h00;
      cmd_count  <= 9'd0;  wrap_setting <= 3'b000;
      write_enable_latch <= 1'b0;
      status1 <= STATUS_RST; status2 <= STATUS_RST; status3 <= STATUS_RST;
    end else if (clk_en) begin
      cmd_opcode <= wr_op_q;
      if (done_w) begin
        cmd_addr  <= addr_q;
        cmd_data  <= d0_q;
        // count saturates at one page
        cmd_count <= cnt_q;
      end
      if (accept_w && op_q == OP_WRAP) wrap_setting <= wrap_q;
      write_enable_latch <= wel_q;
      status1 <= {s1_q[7:2], wel_q, busy};
      status2 <= s2_q;
      status3 <= s3_q;
    end
  end

  // ==========================================================================
  // checks
  property p_busy_blocks;
    @(posedge mclk) disable iff (!rst_n_q)
    (done_w && busy) |=> !cmd_valid || $past(cls_w) == CL_SUSP;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("instruction accepted while busy");

  property p_wel_set;
    @(posedge mclk) disable iff (!rst_n_q)
    (accept_w && op_q == OP_WREN) |=> wel_q;
  endproperty
  a_wel_set: assert property (p_wel_set)
    else $error("write enable not set");

  property p_wel_clr;
    @(posedge mclk) disable iff (!rst_n_q)
    (accept_w && op_q == OP_WRDI && !wsr_busy_w) |=> !wel_q;
  endproperty
  a_wel_clr: assert property (p_wel_clr)
    else $error("write disable ignored");

  property p_unaligned;
    @(posedge mclk) disable iff (!rst_n_q)
    (done_w && !aligned_q && cls_w == CL_WRITE) |=> !cmd_valid;
  endproperty
  a_unaligned: assert property (p_unaligned)
    else $error("mid-byte write executed");

  property p_need_wel;
    @(posedge mclk) disable iff (!rst_n_q)
    (done_w && cls_w == CL_WRITE && !wel_q && !vol_q) |=> !cmd_valid;
  endproperty
  a_need_wel: assert property (p_need_wel)
    else $error("write without latch");

  property p_protect;
    @(posedge mclk) disable iff (!rst_n_q)
    (done_w && cls_w == CL_WRITE && region_protected) |=> !cmd_valid;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected region written");

  property p_wsr_busy;
    @(posedge mclk) disable iff (!rst_n_q)
    (clk_en && wsr_q == 1 && !array_busy) |=> !busy;
  endproperty
  a_wsr_busy: assert property (p_wsr_busy)
    else $error("busy outlasts status write");

  property p_wsr_start;
    @(posedge mclk) disable iff (!rst_n_q)
    (accept_w && op_q == OP_WRSR1 && !vol_q) |=> busy [*2];
  endproperty
  a_wsr_start: assert property (p_wsr_start)
    else $error("status write cycle not busy");

endmodule : flash_cmd_decoder

/* File: tb/spi_host_model.sv */
/*
  Host controller model: frames instructions, shifts fields on 1/2/4
  lines and reads single-line replies on io line one and dual replies on io lines zero and one.
*/
`timescale 1ns/10ps

module spi_host_model (
  // link pins
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      io_in,
  // device replies
  input  wire logic [3:0] io_out
);
  localparam realtime HALF = 62.5;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end

  // ==========================================================================
  // framing
  task automatic open_frame();
    cs_n = 1'b0;
    #HALF;
  endtask : open_frame

  // released lines show the inverse of their last level
  task automatic close_frame();
    #HALF;
    cs_n = 1'b1;
    io_in = ~io_in;
    #500;
  endtask : close_frame

  // ==========================================================================
  // shifting, msb first, clock stands low outside frames
  task automatic put_byte(input logic [7:0] b, input int lanes,
                          input int clks);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < clks; i++) begin
      if (lanes == 1) begin
        io_in[0] = s[7];
      end else if (lanes == 2) begin
        io_in[1:0] = s[7:6];
      end else begin
        io_in = s[7:4];
      end
      s = s << lanes;
      #HALF;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
  endtask : put_byte

  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      #HALF;
      b = {b[6:0], io_out[1]};
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
  endtask : get_byte

  task automatic get_dual(output logic [7:0] b);
    for (int i = 0; i < 4; i++) begin
      #HALF;
      b = {b[5:0], io_out[1:0]};
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
  endtask : get_dual

endmodule : spi_host_model

/* File: tb/serial_flash_instruction_decoder_tb.sv */
/*
  Self-checking bench for the serial flash instruction decoder.
  Assumes spi_host_model on the link and the package constants.
*/
`timescale 1ns/10ps

`define CHECK(got, exp, msg) begin total_checks++; \
  if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: %s", $time, msg); end end

module serial_flash_instruction_decoder_tb import flash_cmd_pkg::*;;
  logic        mclk, reset_n, clk_en, array_busy, region_protected;
  logic [7:0]  read_byte, status1, status2, status3, cmd_opcode;
  logic [7:0]  cmd_data, r1, r2;
  logic [23:0] cmd_addr;
  logic [8:0]  cmd_count;
  logic [2:0]  wrap_setting;
  logic        cmd_valid, write_enable_latch, busy;
  wire         sclk, cs_n;
  wire  [3:0]  io_in, io_out, io_oe_n;
  int          err_count, total_checks, pulses, base;

  spi_host_model host (
    .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

  flash_cmd_decoder #(.WSR_CYCLES(200)) dut (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .sclk(sclk),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .array_busy(array_busy), .region_protected(region_protected),
    .read_byte(read_byte), .status1(status1), .status2(status2),
    .status3(status3), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count),
    .wrap_setting(wrap_setting), .write_enable_latch(write_enable_latch),
    .busy(busy));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) if (cmd_valid === 1'b1) pulses++;

  // ==========================================================================
  // helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic one(input logic [7:0] op);
    base = pulses;
    host.open_frame();
    host.put_byte(op, 1, 8);
    host.close_frame();
  endtask : one

  task automatic head(input logic [7:0] op, input logic [23:0] a);
    base = pulses;
    host.open_frame();
    host.put_byte(op, 1, 8);
    for (int i = 2; i >= 0; i--) host.put_byte(a[i*8 +: 8], 1, 8);
  endtask : head

  task automatic rdst(input logic [7:0] op);
    host.open_frame();
    host.put_byte(op, 1, 8);
    host.get_byte(r1);
    host.get_byte(r2);
    host.close_frame();
  endtask : rdst

  task automatic wrsr1(input logic [7:0] b);
    host.open_frame();
    host.put_byte(OP_WRSR1, 1, 8);
    host.put_byte(b, 1, 8);
    host.close_frame();
  endtask : wrsr1

  task automatic pulsed(input int n, input string msg);
    `CHECK(pulses - base, n, msg)
  endtask : pulsed

  task automatic core(input logic b, input logic p);
    @(posedge mclk);
    #1;
    array_busy = b;
    region_protected = p;
    #1;
  endtask : core

  // ==========================================================================
  // scenarios
  task automatic t_latch();
    `CHECK(busy, 1'b0, "busy at reset")
    one(OP_WREN);
    `CHECK(write_enable_latch, 1'b1, "latch not set")
    `CHECK(status1[1], 1'b1, "status latch bit")
    rdst(OP_RDSR1);
    `CHECK({r1, r2}, {2{STATUS_RST | 8'h02}}, "status one")
    rdst(OP_RDSR2);
    `CHECK({r1, r2}, {2{STATUS_RST}}, "status two")
    one(8'hFF);
    pulsed(0, "unknown pulsed");
    `CHECK(write_enable_latch, 1'b1, "unknown acted")
    one(OP_WRDI);
    `CHECK(write_enable_latch, 1'b0, "latch not cleared")
    one(OP_VWREN);
    `CHECK(write_enable_latch, 1'b0, "volatile set latch")
    wrsr1(8'h24);
    `CHECK(status1, 8'h24, "volatile status write")
    `CHECK(busy, 1'b0, "volatile write busy")
    one(OP_RSTEN);
    one(OP_RST);
    `CHECK(status1, STATUS_RST, "reset reload")
    $display("test latch done");
  endtask : t_latch

  task automatic t_prog();
    one(OP_WREN);
    head(OP_PP, 24'h01_2345);
    host.put_byte(8'hA5, 1, 8);
    host.close_frame();
    pulsed(1, "program lost");
    `CHECK(cmd_opcode, OP_PP, "program opcode")
    `CHECK(cmd_addr, 24'h01_2345, "program address")
    `CHECK(cmd_data, 8'hA5, "program data")
    `CHECK(cmd_count, 9'd1, "program count")
    one(OP_WRDI);
    head(OP_PP, 24'h00_0100);
    host.put_byte(8'h11, 1, 8);
    host.close_frame();
    pulsed(0, "program unlatched");
    one(OP_WREN);
    head(OP_QPP, 24'h00_0200);
    host.put_byte(8'h5C, 4, 2);
    host.close_frame();
    `CHECK(cmd_data, 8'h5C, "quad data")
    one(OP_WREN);
    head(OP_QPP, 24'h00_0300);
    for (int i = 0; i < PAGE_BYTES + 2; i++) host.put_byte(i[7:0], 4, 2);
    host.close_frame();
    pulsed(1, "long quad program");
    `CHECK(cmd_count, 9'(PAGE_BYTES), "count past page")
    $display("test program done");
  endtask : t_prog

  task automatic t_erase();
    one(OP_WREN);
    head(OP_SE, 24'h00_1000);
    host.put_byte(8'hFF, 1, 3);
    host.close_frame();
    pulsed(0, "unaligned erase");
    host.open_frame();
    host.put_byte(OP_RDSR1, 1, 8);
    host.put_byte(8'h00, 1, 3);
    host.close_frame();
    core(1'b0, 1'b1);
    head(OP_SE, 24'h00_1000);
    host.close_frame();
    pulsed(0, "protected erase");
    core(1'b0, 1'b0);
    head(OP_SE, 24'h00_2000);
    host.close_frame();
    pulsed(1, "erase lost");
    `CHECK(cmd_opcode, OP_SE, "erase opcode")
    $display("test erase done");
  endtask : t_erase

  task automatic t_busy();
    one(OP_WRDI);
    core(1'b1, 1'b0);
    `CHECK(busy, 1'b1, "busy not shown")
    one(OP_WREN);
    `CHECK(write_enable_latch, 1'b0, "enable while busy")
    rdst(OP_RDSR1);
    `CHECK(r2[0], 1'b1, "busy bit read")
    one(OP_SUSP);
    pulsed(1, "suspend refused");
    `CHECK(cmd_opcode, OP_SUSP, "suspend opcode")
    core(1'b0, 1'b0);
    one(OP_RESM);
    `CHECK(cmd_opcode, OP_RESM, "resume opcode")
    $display("test busy done");
  endtask : t_busy

  task automatic t_sec();
    logic [7:0] regs [3];
    regs = '{SEC_REG1, SEC_REG2, SEC_REG3};
    one(OP_WREN);
    head(OP_SCPR, 24'h00_5010);
    host.put_byte(8'h77, 1, 8);
    host.close_frame();
    pulsed(0, "bad security address");
    foreach (regs[k]) begin
      one(OP_WREN);
      head(OP_SCER, {SEC_HI_BYTE, regs[k], 8'h00});
      host.close_frame();
      pulsed(1, "security erase lost");
    end
    $display("test security done");
  endtask : t_sec

  task automatic t_wsr();
    one(OP_WREN);
    one(OP_WREN);
    wrsr1(8'h1C);
    `CHECK(busy, 1'b1, "write cycle idle")
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk);
    `CHECK(busy, 1'b0, "busy stuck")
    repeat (2) @(posedge mclk);
    `CHECK(status1, 8'h1C, "status one written")
    $display("test status write done");
  endtask : t_wsr

  task automatic t_mode();
    host.open_frame();
    host.put_byte(OP_WRAP, 1, 8);
    for (int i = 0; i < WRAP_DUMMIES; i++) host.put_byte(8'h00, 1, 8);
    host.put_byte(8'h00, 1, 6);
    host.put_byte(8'h50, 4, 1);
    host.put_byte(8'h00, 1, 1);
    host.close_frame();
    `CHECK(wrap_setting, 3'b101, "wrap bits")
    host.open_frame();
    host.put_byte(OP_DIOREAD, 1, 8);
    for (int i = 0; i < 3; i++) host.put_byte(8'h12, 2, 4);
    host.put_byte(8'hF0, 2, 4);
    host.get_dual(r1);
    host.close_frame();
    `CHECK(r1, 8'h3C, "dual read data")
    `CHECK(io_oe_n, 4'hF, "lines left driven")
    $display("test mode done");
  endtask : t_mode

  initial begin
    #300000;
    err_count++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    array_busy = 1'b0;
    region_protected = 1'b0;
    read_byte = 8'h3C;
    repeat (8) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (6) @(posedge mclk);
    t_latch();
    t_prog();
    t_erase();
    t_busy();
    t_sec();
    t_wsr();
    t_mode();
    close_out();
  end

endmodule : serial_flash_instruction_decoder_tb
